/* File: hw/sbg_pkg.sv */
// Shared constants and types for the serial port baud generator.
// Assumes one APB master and one system clock for the whole block.
package sbg_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] OFF_RECEIVE_STATUS_CONTROL = 8'h04;
    localparam logic [7:0] OFF_BAUD_RELOAD_LOW = 8'h08;
    localparam logic [7:0] OFF_BAUD_RELOAD_HIGH = 8'h0C;
    localparam logic [7:0] OFF_TRANSMIT_STATUS_CONTROL = 8'h10;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_PORT_ENABLE = 7;
    localparam int BIT_SYNC_MODE = 4;
    localparam int BIT_HIGH_SPEED = 2;
    localparam int IRQ_WAKE = 0;
    localparam int IRQ_ABD_DONE = 1;
    localparam int IRQ_ABD_OVF = 2;
    localparam int IRQ_WIDTH = 3;
    // Baud control field positions
    localparam int BIT_ABD_OVF = 7;
    localparam int BIT_RX_IDLE = 6;
    localparam int BIT_RSVD_HIGH = 5;
    localparam int BIT_POLARITY = 4;
    localparam int BIT_WIDE = 3;
    localparam int BIT_RSVD_LOW = 2;
    localparam int BIT_WAKE_EN = 1;
    localparam int BIT_ABD_EN = 0;

    // ------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RECEIVE_STATUS_CONTROL_WR_MASK = 8'hF9;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_WR_MASK = 8'hFD;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // ------------------------------------------------------------
    // Divide factors of the prescaler, minus one
    // ------------------------------------------------------------
    localparam logic [5:0] PRE_LAST_64 = 6'h3F;
    localparam logic [5:0] PRE_LAST_16 = 6'h0F;
    localparam logic [5:0] PRE_LAST_4 = 6'h03;
    localparam logic [5:0] PRE_ZERO = 6'h00;
    localparam logic [15:0] TIMER_ZERO = 16'h0000;

    // Software-writable fields of the baud control register
    typedef struct packed {
        logic clockDataPolarity;
        logic wideCounterSelect;
        logic wakeUpEnable;
        logic autoBaudEnable;
    } sbg_baud_ctl_s;
endpackage

/* File: hw/sbg_baud_gen.sv */
// Baud timer with its control registers, reached over APB.
// Assumes the receiver supplies idle, wake and auto-baud status lines
// synchronous to clock, and the transmitter supplies raw serial data.
//
// What this block does
// [R1] One baud timer for async and sync
// [R2] Narrow counter after reset; wide bit widens
// [R3] Free running period from reload bytes
// [R4] Sync mode ignores high-speed select
// [R5] Async narrow slow divides by sixty-four
// [R6] Async narrow fast or wide slow: sixteen
// [R7] Async wide fast and sync: divide four
// [R8] Reload byte write clears the timer
// [R9] Software checks idle before clock change
// [R10] Software picks fast or wide for accuracy
// [R11] Async polarity inverts transmit data
// [R12] Sync polarity picks rising or falling edge
// [R13] Wake enable waits, flags, then self-clears
// [R14] Auto-baud enable self-clears; sync ignores both
// [R15] Baud control layout, reserved bits zero
// [R16] Sync and high-speed bits in transmit register
// [R17] Tick at terminal count, restart, when enabled
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module sbg_baud_gen
    import sbg_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxIdle,
    input wire logic wakeEvent,
    input wire logic autoBaudDone,
    input wire logic autoBaudOvf,
    input wire logic txDataRaw,
    output logic txPin,
    output logic baudTick,
    output logic syncClockRising,
    output logic rxIntSet,
    output logic irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    sbg_baud_ctl_s baudCtl_q;
    logic auto_baud_overflow_q;
    logic [7:0] receive_status_control_q;
    logic [7:0] reloadLow_q;
    logic [7:0] reloadHigh_q;
    logic [7:0] transmit_status_control_q;
    logic [IRQ_WIDTH-1:0] irqStat_q;
    logic [IRQ_WIDTH-1:0] irqMask_q;
    logic [5:0] presc_q;
    logic [15:0] timer_q;
    logic [31:0] readData_d;
    logic addrHit;
    logic accessDone;
    logic wrEn;
    logic syncMode;
    logic highSpeed;
    logic portOn;
    logic [5:0] prescLast;
    logic [15:0] topCount;
    logic prescWrap;
    logic timerWrap;
    logic reloadWrite;
    logic wakeFire;
    logic abdFire;
    logic [IRQ_WIDTH-1:0] irqEvents;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign accessDone = psel && penable && pready;
    assign wrEn = accessDone && pwrite;

    // Address decode and read mux, unmapped reads give zero
    always_comb begin
        addrHit = 1'b1;
        readData_d = 32'h0000_0000;
        unique case (paddr)
            OFF_BAUD_CONTROL: begin
                readData_d[BIT_ABD_OVF] = auto_baud_overflow_q; // [R15]
                readData_d[BIT_RX_IDLE] = rxIdle;
                readData_d[BIT_POLARITY] = baudCtl_q.clockDataPolarity;
                readData_d[BIT_WIDE] = baudCtl_q.wideCounterSelect;
                readData_d[BIT_WAKE_EN] = baudCtl_q.wakeUpEnable;
                readData_d[BIT_ABD_EN] = baudCtl_q.autoBaudEnable;
            end
            OFF_RECEIVE_STATUS_CONTROL: readData_d[7:0] = receive_status_control_q;
            OFF_BAUD_RELOAD_LOW: readData_d[7:0] = reloadLow_q;
            OFF_BAUD_RELOAD_HIGH: readData_d[7:0] = reloadHigh_q;
            OFF_TRANSMIT_STATUS_CONTROL: readData_d[7:0] = transmit_status_control_q;
            OFF_IRQ_STATUS: readData_d[IRQ_WIDTH-1:0] = irqStat_q;
            OFF_IRQ_MASK: readData_d[IRQ_WIDTH-1:0] = irqMask_q;
            default: addrHit = 1'b0;
        endcase
    end

    // Ready, error and read data all come from flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addrHit;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= readData_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    assign syncMode = transmit_status_control_q[BIT_SYNC_MODE]; // [R16]
    assign highSpeed = transmit_status_control_q[BIT_HIGH_SPEED]; // [R16]
    assign portOn = receive_status_control_q[BIT_PORT_ENABLE];
    assign reloadWrite = wrEn && (paddr == OFF_BAUD_RELOAD_LOW ||
        paddr == OFF_BAUD_RELOAD_HIGH);

    // Plain read/write registers; reserved bits never store
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            receive_status_control_q <= RST_BYTE;
            transmit_status_control_q <= RST_BYTE;
            reloadLow_q <= RST_BYTE;
            reloadHigh_q <= RST_BYTE;
            irqMask_q <= IRQ_RST;
        end else if (wrEn) begin
            unique case (paddr)
                OFF_RECEIVE_STATUS_CONTROL:
                    receive_status_control_q <= pwdata[7:0] & RECEIVE_STATUS_CONTROL_WR_MASK;
                OFF_TRANSMIT_STATUS_CONTROL:
                    transmit_status_control_q <= pwdata[7:0] & TRANSMIT_STATUS_CONTROL_WR_MASK;
                OFF_BAUD_RELOAD_LOW: reloadLow_q <= pwdata[7:0];
                OFF_BAUD_RELOAD_HIGH: reloadHigh_q <= pwdata[7:0];
                OFF_IRQ_MASK: irqMask_q <= pwdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end
    end

    // Wake and auto-baud enables are ignored in sync mode
    assign wakeFire = wakeEvent && baudCtl_q.wakeUpEnable && !syncMode;
    assign abdFire = autoBaudDone && baudCtl_q.autoBaudEnable &&
        !syncMode; // [R14]

    // Baud control: hardware clears win over a same-cycle write,
    // since a finished detection must not be restarted by accident
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baudCtl_q <= '0; // [R2]
        end else begin
            if (wrEn && paddr == OFF_BAUD_CONTROL) begin
                baudCtl_q.clockDataPolarity <= pwdata[BIT_POLARITY];
                baudCtl_q.wideCounterSelect <= pwdata[BIT_WIDE]; // [R2]
                baudCtl_q.wakeUpEnable <= pwdata[BIT_WAKE_EN];
                baudCtl_q.autoBaudEnable <= pwdata[BIT_ABD_EN];
            end
            if (wakeFire) begin
                baudCtl_q.wakeUpEnable <= 1'b0; // [R13]
            end
            if (abdFire) begin
                baudCtl_q.autoBaudEnable <= 1'b0; // [R14]
            end
        end
    end

    // Overflow flag: set by the receiver, cleared on a new start
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            auto_baud_overflow_q <= 1'b0;
        end else if (autoBaudOvf && !syncMode) begin
            auto_baud_overflow_q <= 1'b1;
        end else if (wrEn && paddr == OFF_BAUD_CONTROL &&
            pwdata[BIT_ABD_EN]) begin
            auto_baud_overflow_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Baud timer
    // ------------------------------------------------------------
    // Prescaler length from the mode bits
    always_comb begin
        if (syncMode) begin
            prescLast = PRE_LAST_4; // [R4] [R7]
        end else if (!baudCtl_q.wideCounterSelect && !highSpeed) begin
            prescLast = PRE_LAST_64; // [R5]
        end else if (baudCtl_q.wideCounterSelect && highSpeed) begin
            prescLast = PRE_LAST_4; // [R7]
        end else begin
            prescLast = PRE_LAST_16; // [R6]
        end
    end

    // Narrow mode only looks at the low reload byte
    assign topCount = baudCtl_q.wideCounterSelect ?
        {reloadHigh_q, reloadLow_q} : {8'h00, reloadLow_q}; // [R3]
    assign prescWrap = (presc_q == prescLast);
    // Greater-or-equal guards a top that shrank under the count
    assign timerWrap = prescWrap && (timer_q >= topCount); // [R17]

    // One shared timer for both modes, n+1 prescaler periods long
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            presc_q <= PRE_ZERO;
            timer_q <= TIMER_ZERO;
        end else if (reloadWrite || !portOn) begin
            presc_q <= PRE_ZERO; // [R8]
            timer_q <= TIMER_ZERO; // [R8]
        end else if (prescWrap) begin
            presc_q <= PRE_ZERO;
            timer_q <= timerWrap ? TIMER_ZERO : timer_q + 16'h0001; // [R1]
        end else begin
            presc_q <= presc_q + 6'h01;
        end
    end

    // Tick output, one clock wide per bit period
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            baudTick <= 1'b0;
        end else begin
            baudTick <= timerWrap && portOn && !reloadWrite; // [R17]
        end
    end

    // ------------------------------------------------------------
    // Pin polarity
    // ------------------------------------------------------------
    // Inversion only in async; in sync the bit names the edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            txPin <= 1'b0;
            syncClockRising <= 1'b0;
        end else begin
            txPin <= txDataRaw ^ (baudCtl_q.clockDataPolarity &&
                !syncMode); // [R11]
            syncClockRising <= baudCtl_q.clockDataPolarity; // [R12]
        end
    end

    // Wake pulse toward the receive interrupt flag
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rxIntSet <= 1'b0;
        end else begin
            rxIntSet <= wakeFire; // [R13]
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign irqEvents = {autoBaudOvf && !syncMode, abdFire, wakeFire};

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irqStat_q <= IRQ_RST;
        end else if (wrEn && paddr == OFF_IRQ_STATUS) begin
            irqStat_q <= (irqStat_q & ~pwdata[IRQ_WIDTH-1:0]) | irqEvents;
        end else begin
            irqStat_q <= irqStat_q | irqEvents;
        end
    end

    // Level output, one clock behind the status
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence reloadWriteSeq;
        reloadWrite && portOn;
    endsequence
    sequence timerClearSeq;
        timer_q == TIMER_ZERO && presc_q == PRE_ZERO && !baudTick;
    endsequence

    AST_RELOAD_CLEARS: assert property (@(posedge clock) // [R8]
        disable iff (!rst_b) reloadWriteSeq |=> timerClearSeq)
        else $error("reload write did not clear the timer");

    AST_SYNC_DIV4: assert property (@(posedge clock) // [R4]
        disable iff (!rst_b) syncMode |-> prescLast == PRE_LAST_4)
        else $error("sync mode divide is not four");

    AST_DIV64: assert property (@(posedge clock) // [R5]
        disable iff (!rst_b)
        (!syncMode && !baudCtl_q.wideCounterSelect && !highSpeed)
        |-> prescLast == PRE_LAST_64)
        else $error("slow narrow async divide is not sixty-four");

    AST_DIV16: assert property (@(posedge clock) // [R6]
        disable iff (!rst_b)
        (!syncMode && (baudCtl_q.wideCounterSelect != highSpeed))
        |-> prescLast == PRE_LAST_16)
        else $error("async divide is not sixteen");

    AST_WIDE_FAST_DIV4: assert property (@(posedge clock) // [R7]
        disable iff (!rst_b)
        (!syncMode && baudCtl_q.wideCounterSelect && highSpeed)
        |-> prescLast == PRE_LAST_4)
        else $error("wide fast async divide is not four");

    AST_NARROW_TOP: assert property (@(posedge clock) // [R3]
        disable iff (!rst_b)
        !baudCtl_q.wideCounterSelect |-> topCount[15:8] == 8'h00)
        else $error("narrow mode uses the high reload byte");

    AST_TX_POLARITY: assert property (@(posedge clock) // [R11]
        disable iff (!rst_b) (rst_b && !syncMode) ##1 1'b1 |->
        txPin == ($past(txDataRaw) ^ $past(baudCtl_q.clockDataPolarity)))
        else $error("transmit pin polarity wrong");

    AST_SYNC_EDGE: assert property (@(posedge clock) // [R12]
        disable iff (!rst_b) $changed(baudCtl_q.clockDataPolarity)
        |=> syncClockRising == $past(baudCtl_q.clockDataPolarity))
        else $error("sync edge select did not follow polarity");

    AST_WAKE_CLEAR: assert property (@(posedge clock) // [R13]
        disable iff (!rst_b) wakeFire |=>
        !baudCtl_q.wakeUpEnable && rxIntSet && irqStat_q[IRQ_WAKE])
        else $error("wake event did not flag and self-clear");

    AST_ABD_CLEAR: assert property (@(posedge clock) // [R14]
        disable iff (!rst_b) abdFire |=> !baudCtl_q.autoBaudEnable)
        else $error("auto-baud enable did not self-clear");

    AST_SYNC_IGNORE: assert property (@(posedge clock) // [R14]
        disable iff (!rst_b) syncMode |-> !wakeFire && !abdFire)
        else $error("sync mode reacted to wake or auto-baud");

    AST_TICK_SPACING: assert property (@(posedge clock) // [R17]
        disable iff (!rst_b) baudTick |=> !baudTick [*3])
        else $error("baud ticks closer than four clocks");

    AST_TICK_NEEDS_PORT: assert property (@(posedge clock) // [R17]
        disable iff (!rst_b) baudTick |-> $past(portOn))
        else $error("tick while port disabled");

    AST_RESERVED_ZERO: assert property (@(posedge clock) // [R15]
        disable iff (!rst_b) paddr == OFF_BAUD_CONTROL |->
        readData_d[BIT_RSVD_HIGH] == 1'b0 && readData_d[BIT_RSVD_LOW] == 1'b0)
        else $error("reserved baud control bits read nonzero");

    AST_OVF_STICKY: assert property (@(posedge clock) // [R15]
        disable iff (!rst_b) (autoBaudOvf && !syncMode) |=> auto_baud_overflow_q)
        else $error("auto-baud overflow flag did not set");

    AST_WRAP_RESTART: assert property (@(posedge clock) // [R17]
        disable iff (!rst_b) (timerWrap && portOn && !reloadWrite) |=>
        (baudTick && timer_q == TIMER_ZERO && presc_q == PRE_ZERO))
        else $error("terminal count did not tick and restart");

    AST_RESET_NARROW: assert property (@(posedge clock) // [R2]
        $rose(rst_b) |-> !baudCtl_q.wideCounterSelect)
        else $error("wide counter set after reset");
endmodule

/* File: sim/sbg_tb.sv */
// Self-checking bench for the baud generator: divide table, reload
// restart, polarity, wake and auto-baud status, register layout.
// Assumes the design package is compiled first; no partner model.
`timescale 1ns/1ps
module tb;
    import sbg_pkg::*;

    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic clock, rst_b, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdData;
    logic pready, pslverr, rdErr;
    logic rxIdle, wakeEvent, autoBaudDone, autoBaudOvf, txDataRaw;
    logic txPin, baudTick, syncClockRising, rxIntSet, irq;
    logic [31:0] g;
    int nFail, nCompared;

    typedef struct {
        logic [7:0] txs, bcon, lo, hi;
        int per;
    } sbg_row_s;
    sbg_row_s rows [8] = '{
        '{8'h00, 8'h00, 8'h02, 8'h01, 192},
        '{8'h04, 8'h00, 8'h03, 8'h01, 64},
        '{8'h00, 8'h08, 8'h01, 8'h00, 32},
        '{8'h00, 8'h08, 8'h01, 8'h01, 4128},
        '{8'h04, 8'h08, 8'h05, 8'h00, 24},
        '{8'h10, 8'h00, 8'h02, 8'h00, 12},
        '{8'h14, 8'h00, 8'h02, 8'h00, 12},
        '{8'h14, 8'h08, 8'h00, 8'h01, 1028}};

    sbg_baud_gen dut_u (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxIdle(rxIdle),
        .wakeEvent(wakeEvent), .autoBaudDone(autoBaudDone),
        .autoBaudOvf(autoBaudOvf), .txDataRaw(txDataRaw), .txPin(txPin),
        .baudTick(baudTick), .syncClockRising(syncClockRising),
        .rxIntSet(rxIntSet), .irq(irq));

    // 100 ns period
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; waits for pready with no assumed latency
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (n >= 100) begin
            nFail++;
            $display("unexpected pready expected 1 seen timeout");
        end
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, {24'h00_0000, d});
    endtask

    task automatic rdc(input string name, input logic [7:0] a,
                       input logic [7:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(name, rdData, {24'h00_0000, exp});
    endtask

    // One-cycle pulse on {overflow, done, wake}, then settle at negedge
    task automatic pulse(input logic [2:0] m);
        @(posedge clock);
        {autoBaudOvf, autoBaudDone, wakeEvent} <= m;
        @(posedge clock);
        {autoBaudOvf, autoBaudDone, wakeEvent} <= 3'b000;
        @(negedge clock);
    endtask

    // Cycles until the next tick; a stuck timer shows as 9001
    task automatic gap(output logic [31:0] q);
        int n;
        n = 0;
        @(negedge clock);
        while (baudTick !== 1'b1 && n < 9000) begin
            @(negedge clock);
            n++;
        end
        q = n + 1;
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog sized well above the longest divide row
    initial begin
        repeat (60000) @(posedge clock);
        nFail++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, psel, penable, pwrite, rxIdle, txDataRaw} = 6'b000000;
        {wakeEvent, autoBaudDone, autoBaudOvf} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clock);
        @(negedge clock);
        chk("outputs in reset", {baudTick, irq, txPin, rxIntSet}, 0);
        @(posedge clock);
        rst_b <= 1'b1;
        // All registers clear, narrow counter by default
        for (int i = 0; i < 7; i++) begin
            rdc("reset value", 8'(4 * i), 8'h00);
        end
        // Divide table: every sync / high-speed / width combination except sync slow wide
        foreach (rows[i]) begin
            wr(OFF_RECEIVE_STATUS_CONTROL, 8'h00);
            wr(OFF_TRANSMIT_STATUS_CONTROL, rows[i].txs);
            wr(OFF_BAUD_CONTROL, rows[i].bcon);
            wr(OFF_BAUD_RELOAD_LOW, rows[i].lo);
            wr(OFF_BAUD_RELOAD_HIGH, rows[i].hi);
            wr(OFF_RECEIVE_STATUS_CONTROL, 8'h80);
            gap(g);
            for (int k = 0; k < 2; k++) begin
                gap(g);
                chk("tick period", g, rows[i].per);
            end
        end
        // Reload write mid-period restarts the count at once
        wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h04);
        wr(OFF_BAUD_CONTROL, 8'h08);
        wr(OFF_BAUD_RELOAD_HIGH, 8'h00);
        wr(OFF_BAUD_RELOAD_LOW, 8'h31);
        gap(g);
        repeat (50) @(posedge clock);
        // Four times fifty clocks from the write edge, plus the tick flop
        wr(OFF_BAUD_RELOAD_LOW, 8'h31);
        gap(g);
        chk("restart gap", g, 201);
        // Polarity: async inverts the pin, sync only picks the edge
        wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h00);
        wr(OFF_BAUD_CONTROL, 8'h10);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            txDataRaw <= k[0];
            if (k == 2) wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h10);
            repeat (3) @(negedge clock);
            chk("tx pin", txPin, k[0] ^ (k < 2));
            chk("edge select", syncClockRising, 1);
        end
        wr(OFF_BAUD_CONTROL, 8'h00);
        repeat (2) @(negedge clock);
        chk("edge select", syncClockRising, 0);
        // Sync mode ignores wake and auto-baud enables
        wr(OFF_BAUD_CONTROL, 8'h03);
        pulse(3'b011);
        chk("wake in sync", rxIntSet, 0);
        rdc("control in sync", OFF_BAUD_CONTROL, 8'h03);
        // Async wake: flag request, enable self-clears, status and irq
        wr(OFF_TRANSMIT_STATUS_CONTROL, 8'h00);
        wr(OFF_BAUD_CONTROL, 8'h02);
        pulse(3'b001);
        chk("wake flag", rxIntSet, 1);
        rdc("wake enable cleared", OFF_BAUD_CONTROL, 8'h00);
        rdc("irq status", OFF_IRQ_STATUS, 8'h01);
        chk("irq masked", irq, 0);
        wr(OFF_IRQ_MASK, 8'h07);
        repeat (2) @(negedge clock);
        chk("irq unmasked", irq, 1);
        wr(OFF_IRQ_STATUS, 8'h01);
        repeat (2) @(negedge clock);
        chk("irq cleared", irq, 0);
        // Auto-baud: overflow shows, done self-clears, start clears overflow
        wr(OFF_BAUD_CONTROL, 8'h01);
        pulse(3'b100);
        rdc("overflow set", OFF_BAUD_CONTROL, 8'h81);
        pulse(3'b010);
        rdc("auto-baud done", OFF_BAUD_CONTROL, 8'h80);
        rdc("irq status", OFF_IRQ_STATUS, 8'h06);
        chk("irq raised", irq, 1);
        wr(OFF_IRQ_STATUS, 8'h06);
        wr(OFF_BAUD_CONTROL, 8'h01);
        rdc("overflow cleared", OFF_BAUD_CONTROL, 8'h01);
        chk("irq after clear", irq, 0);
        // Layout, reserved bits, read-only idle flag
        @(posedge clock);
        rxIdle <= 1'b1;
        wr(OFF_BAUD_CONTROL, 8'hFF);
        rdc("control layout", OFF_BAUD_CONTROL, 8'h5B);
        wr(OFF_TRANSMIT_STATUS_CONTROL, 8'hFF);
        rdc("transmit layout", OFF_TRANSMIT_STATUS_CONTROL, 8'hFD);
        wr(OFF_RECEIVE_STATUS_CONTROL, 8'hFF);
        rdc("receive layout", OFF_RECEIVE_STATUS_CONTROL, 8'hF9);
        // Unmapped address answers with an error and zero data
        wr(8'h1C, 8'hFF);
        chk("write error", rdErr, 1);
        rdc("unmapped data", 8'h1C, 8'h00);
        chk("read error", rdErr, 1);
        // Mid-run reset: outputs drop, narrow counter and port off again
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(negedge clock);
        chk("outputs in reset", {baudTick, irq, txPin, syncClockRising}, 0);
        @(posedge clock);
        rst_b <= 1'b1;
        rdc("control after reset", OFF_BAUD_CONTROL, 8'h40);
        rdc("receive after reset", OFF_RECEIVE_STATUS_CONTROL, 8'h00);
        end_sim();
    end
endmodule
